// ===== rtl/kbc_host_port.sv
// Module: keyboard controller host port, command interpreter and buffers
`timescale 1ns/10ps
`default_nettype none
// Contract
// RL1: Port 64h read gives status, write commands
// RL2: Status bit 3 records last write's address bit
// RL3: Input-full set by writes, cleared on consumption
// RL4: Output-full set on byte, cleared by read
// RL5: Port 64h write loads command, marks command
// RL6: Keyboard data raises keyboard interrupt line
// RL7: 20h reads, 60h writes configuration byte
// RL8: A4h answers FAh installed, F1h otherwise
// RL9: A5h then characters, 00h ends password load
// RL10: A6h locks until password typed correctly
// RL11: A7h/A8h set/clear bit 5, pointer clock
// RL12: A9h/ABh line tests return codes 00h-04h
// RL13: AAh inhibits both interfaces, returns 55h
// RL14: ADh/AEh set/clear bit 4, keyboard disable
// RL15: C0h/D0h copy input/output port to buffer
// RL16: C2h/C3h mirror input nibbles until next command
// RL17: D1h writes output port, bit 1 only
// RL18: D2h/D3h echo next byte with interrupts
// RL19: D4h sends next data byte to pointer
// RL20: E0h returns test inputs in bits 1:0
// RL21: F0h-FFh pulse output bits where zero
// RL22: Port 60h write is data, routed by state
// RL23: Host polls status before reading or writing
module kbc_host_port (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic host_address_bit_two,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata_reg,
   output logic keyboard_interrupt_line_reg,
   output logic pointer_interrupt_line_reg,
   input wire logic rx_valid,
   input wire kbc_pkg::kbc_byte_t rx_word,
   output logic rx_ready_reg,
   output logic tx_valid_reg,
   output kbc_pkg::kbc_byte_t tx_word_reg,
   input wire logic tx_ready,
   input wire logic [7:0] in_port_pin,
   input wire logic [1:0] test_pin,
   input wire logic [3:0] line_in,
   output logic [3:0] line_out_reg,
   output logic [3:0] line_oe_reg,
   output logic [7:0] out_port_reg
);
   // ************************************************
   // Pin synchronisers (lines: aux dat, aux clk, kbd dat, kbd clk)
   // ************************************************
   logic [13:0] sync1_reg, sync2_reg;
   logic [7:0] inp_s;
   logic [1:0] test_s;
   logic [3:0] line_s;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= 14'h0000;
         sync2_reg <= 14'h0000;
      end else if (clk_en) begin
         sync1_reg <= {in_port_pin, test_pin, line_in};
         sync2_reg <= sync1_reg;
      end
   end
   assign inp_s = sync2_reg[13:6];
   assign test_s = sync2_reg[5:4];
   assign line_s = sync2_reg[3:0];

   // ************************************************
   // Two-entry transmit buffer: output stage plus skid
   // ************************************************
   logic push;
   kbc_pkg::kbc_byte_t push_word, skid_reg, skid_next, tx_word_next;
   logic skid_v_reg, skid_v_next, tx_valid_next;
   always_comb begin
      tx_valid_next = tx_valid_reg;
      tx_word_next = tx_word_reg;
      skid_v_next = skid_v_reg;
      skid_next = skid_reg;
      if (tx_valid_reg && tx_ready) begin
         tx_valid_next = 1'b0;
      end
      if (!tx_valid_next && skid_v_reg) begin
         tx_valid_next = 1'b1;
         tx_word_next = skid_reg;
         skid_v_next = 1'b0;
      end
      if (push) begin
         if (!tx_valid_next) begin
            tx_valid_next = 1'b1;
            tx_word_next = push_word;
         end else begin
            skid_v_next = 1'b1;
            skid_next = push_word;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_valid_reg <= 1'b0;
         tx_word_reg <= '0;
         skid_v_reg <= 1'b0;
         skid_reg <= '0;
      end else if (clk_en) begin
         tx_valid_reg <= tx_valid_next;
         tx_word_reg <= tx_word_next;
         skid_v_reg <= skid_v_next;
         skid_reg <= skid_next;
      end
   end

   // ************************************************
   // Interpreter state
   // ************************************************
   logic ibf_reg, ibf_next, cd_reg, cd_next, obf_reg, obf_next;
   logic [7:0] ib_reg, ib_next, cfg_reg, cfg_next, outp_reg, outp_next;
   kbc_pkg::kbc_byte_t ob_reg, ob_next;
   kbc_pkg::kbc_pend_t pend_reg, pend_next;
   kbc_pkg::kbc_test_t ts_reg, ts_next;
   logic poll_hi_reg, poll_hi_next, poll_lo_reg, poll_lo_next;
   logic lock_reg, lock_next, t_aux_reg, t_aux_next;
   logic [8:0] cnt_reg, cnt_next;
   logic [3:0] pmask_reg, pmask_next;
   logic [7:0] pw_mem [kbc_pkg::PW_MAX];
   logic [7:0] pw_mem_next [kbc_pkg::PW_MAX];
   logic [3:0] pw_len_reg, pw_len_next, pw_idx_reg, pw_idx_next;
   logic [7:0] rdata_next, status, out_pin_next;
   logic [3:0] oe_next;
   logic rx_take, consume, rxr_next, kirq_next, airq_next;

   // Gating on tx space keeps forwarded bytes from being lost on a stall
   assign rx_take = rx_valid && rx_ready_reg;
   assign consume = ibf_reg && !rx_take && !obf_reg && ts_reg == kbc_pkg::TS_IDLE
                    && !skid_v_reg && pmask_reg == 4'h0;

   always_comb begin
      status = {kbc_pkg::STAT_GP_RST, cd_reg, cfg_reg[kbc_pkg::CFG_SYS], ibf_reg, obf_reg};
      if (poll_hi_reg) begin
         status[7:4] = inp_s[7:4]; // RL16
      end
      if (poll_lo_reg) begin
         status[3:0] = inp_s[3:0]; // RL16
      end
   end

   always_comb begin
      ibf_next = ibf_reg;
      cd_next = cd_reg;
      ib_next = ib_reg;
      obf_next = obf_reg;
      ob_next = ob_reg;
      cfg_next = cfg_reg;
      outp_next = outp_reg;
      pend_next = pend_reg;
      ts_next = ts_reg;
      poll_hi_next = poll_hi_reg;
      poll_lo_next = poll_lo_reg;
      lock_next = lock_reg;
      t_aux_next = t_aux_reg;
      cnt_next = cnt_reg;
      pmask_next = pmask_reg;
      pw_mem_next = pw_mem;
      pw_len_next = pw_len_reg;
      pw_idx_next = pw_idx_reg;
      rdata_next = host_rdata_reg;
      push = 1'b0;
      push_word = '0;
      // Host read: status or output buffer
      if (host_rd) begin
         if (host_address_bit_two) begin
            rdata_next = status; // RL1
         end else begin
            rdata_next = ob_reg.data;
            obf_next = 1'b0; // RL4
         end
      end
      // Byte from the serial side
      if (rx_take) begin
         if (lock_reg) begin
            if (!rx_word.aux) begin
               // Wrong character restarts the match from the first one
               if (rx_word.data == pw_mem[pw_idx_reg[2:0]]) begin // RL10
                  pw_idx_next = pw_idx_reg + 4'h1;
                  if (pw_idx_reg + 4'h1 == pw_len_reg) begin
                     lock_next = 1'b0;
                  end
               end else begin
                  pw_idx_next = 4'h0;
               end
            end
         end else if (!(rx_word.aux ? cfg_reg[kbc_pkg::CFG_ADIS]
                                    : cfg_reg[kbc_pkg::CFG_KDIS])) begin
            obf_next = 1'b1; // RL4 RL6
            ob_next = rx_word;
         end
      end
      // Pulse timer
      if (pmask_reg != 4'h0) begin
         cnt_next = cnt_reg - 9'h001;
         if (cnt_reg == 9'h001) begin
            pmask_next = 4'h0;
         end
      end
      // Line test: released phase spots stuck low, driven phase stuck high
      unique case (ts_reg)
         kbc_pkg::TS_IDLE: begin
         end
         kbc_pkg::TS_REL: begin
            cnt_next = cnt_reg - 9'h001;
            if (cnt_reg == 9'h001) begin
               cnt_next = 9'(kbc_pkg::SETTLE_CYC);
               ts_next = kbc_pkg::TS_DRIVE;
               if (!line_s[t_aux_reg ? 2 : 0] || !line_s[t_aux_reg ? 3 : 1]) begin
                  ts_next = kbc_pkg::TS_IDLE;
                  obf_next = 1'b1;
                  ob_next = {t_aux_reg, line_s[t_aux_reg ? 2 : 0] ? kbc_pkg::LT_DAT_LO
                                                                  : kbc_pkg::LT_CLK_LO}; // RL12
               end
            end
         end
         kbc_pkg::TS_DRIVE: begin
            cnt_next = cnt_reg - 9'h001;
            if (cnt_reg == 9'h001) begin
               ts_next = kbc_pkg::TS_IDLE;
               obf_next = 1'b1;
               ob_next = {t_aux_reg, kbc_pkg::LT_OK}; // RL12
               if (line_s[t_aux_reg ? 2 : 0]) begin
                  ob_next.data = kbc_pkg::LT_CLK_HI;
               end else if (line_s[t_aux_reg ? 3 : 1]) begin
                  ob_next.data = kbc_pkg::LT_DAT_HI;
               end
            end
         end
      endcase
      // Consume the input buffer
      if (consume) begin
         ibf_next = 1'b0; // RL3
         if (lock_reg) begin
            pend_next = kbc_pkg::PD_NONE; // RL10
         end else if (cd_reg) begin
            pend_next = kbc_pkg::PD_NONE;
            poll_hi_next = 1'b0; // RL16
            poll_lo_next = 1'b0;
            unique case (ib_reg)
               kbc_pkg::CMD_RD_CFG: begin
                  obf_next = 1'b1; // RL7
                  ob_next = {1'b0, cfg_reg};
               end
               kbc_pkg::CMD_WR_CFG: pend_next = kbc_pkg::PD_CFG; // RL7
               kbc_pkg::CMD_PW_TEST: begin
                  obf_next = 1'b1; // RL8
                  ob_next = {1'b0, pw_len_reg != 4'h0 ? kbc_pkg::RSP_PW_YES : kbc_pkg::RSP_PW_NO};
               end
               kbc_pkg::CMD_PW_LOAD: begin
                  pend_next = kbc_pkg::PD_PW; // RL9
                  pw_idx_next = 4'h0;
               end
               kbc_pkg::CMD_PW_LOCK: begin
                  // Locking without a stored password would never release
                  lock_next = pw_len_reg != 4'h0; // RL10
                  pw_idx_next = 4'h0;
               end
               kbc_pkg::CMD_AUX_DIS: cfg_next[kbc_pkg::CFG_ADIS] = 1'b1; // RL11
               kbc_pkg::CMD_AUX_EN: cfg_next[kbc_pkg::CFG_ADIS] = 1'b0; // RL11
               kbc_pkg::CMD_AUX_TEST, kbc_pkg::CMD_KBD_TEST: begin
                  ts_next = kbc_pkg::TS_REL; // RL12
                  t_aux_next = ib_reg == kbc_pkg::CMD_AUX_TEST;
                  cnt_next = 9'(kbc_pkg::SETTLE_CYC);
               end
               kbc_pkg::CMD_INIT: begin
                  cfg_next[kbc_pkg::CFG_KDIS] = 1'b1; // RL13
                  cfg_next[kbc_pkg::CFG_ADIS] = 1'b1;
                  obf_next = 1'b1;
                  ob_next = {1'b0, kbc_pkg::RSP_INIT};
               end
               kbc_pkg::CMD_KBD_DIS: cfg_next[kbc_pkg::CFG_KDIS] = 1'b1; // RL14
               kbc_pkg::CMD_KBD_EN: cfg_next[kbc_pkg::CFG_KDIS] = 1'b0; // RL14
               kbc_pkg::CMD_RD_INP: begin
                  obf_next = 1'b1; // RL15
                  ob_next = {1'b0, inp_s};
               end
               kbc_pkg::CMD_POLL_HI: poll_hi_next = 1'b1; // RL16
               kbc_pkg::CMD_POLL_LO: poll_lo_next = 1'b1; // RL16
               kbc_pkg::CMD_RD_OUTP: begin
                  obf_next = 1'b1; // RL15
                  ob_next = {1'b0, outp_reg};
               end
               kbc_pkg::CMD_WR_OUTP: pend_next = kbc_pkg::PD_OUTP; // RL17
               kbc_pkg::CMD_ECHO_KBD: pend_next = kbc_pkg::PD_ECHO_K; // RL18
               kbc_pkg::CMD_ECHO_AUX: pend_next = kbc_pkg::PD_ECHO_A; // RL18
               kbc_pkg::CMD_WR_AUX: pend_next = kbc_pkg::PD_AUX; // RL19
               kbc_pkg::CMD_RD_TEST: begin
                  obf_next = 1'b1; // RL20
                  ob_next = {1'b0, 6'h00, test_s};
               end
               default: begin
                  if (ib_reg[7:4] == kbc_pkg::CMD_PULSE_HI && ib_reg[3:0] != 4'hf) begin
                     pmask_next = ~ib_reg[3:0]; // RL21
                     cnt_next = 9'(kbc_pkg::PULSE_CYC);
                  end
               end
            endcase
         end else begin
            pend_next = kbc_pkg::PD_NONE; // RL22
            unique case (pend_reg)
               kbc_pkg::PD_CFG: cfg_next = ib_reg; // RL7
               kbc_pkg::PD_PW: begin
                  if (ib_reg == kbc_pkg::PW_END) begin
                     pw_len_next = pw_idx_reg; // RL9
                     pw_idx_next = 4'h0;
                  end else begin
                     pend_next = kbc_pkg::PD_PW;
                     // Characters beyond the store are dropped
                     if (pw_idx_reg != 4'(kbc_pkg::PW_MAX)) begin
                        pw_mem_next[pw_idx_reg[2:0]] = ib_reg; // RL9
                        pw_idx_next = pw_idx_reg + 4'h1;
                     end
                  end
               end
               kbc_pkg::PD_OUTP: outp_next[kbc_pkg::OUTP_GATE] = ib_reg[kbc_pkg::OUTP_GATE]; // RL17
               kbc_pkg::PD_ECHO_K, kbc_pkg::PD_ECHO_A: begin
                  obf_next = 1'b1; // RL18
                  ob_next = {pend_reg == kbc_pkg::PD_ECHO_A, ib_reg};
               end
               kbc_pkg::PD_AUX: begin
                  push = 1'b1; // RL19
                  push_word = {1'b1, ib_reg};
               end
               kbc_pkg::PD_NONE: begin
                  push = 1'b1; // RL22
                  push_word = {1'b0, ib_reg};
               end
               default: begin
               end
            endcase
         end
      end
      // A new write wins over a consumption in the same cycle
      if (host_wr) begin
         ibf_next = 1'b1; // RL3
         ib_next = host_wdata; // RL5 RL22
         cd_next = host_address_bit_two; // RL2
      end
      rxr_next = !obf_next && ts_next == kbc_pkg::TS_IDLE;
      kirq_next = obf_next && !ob_next.aux && cfg_next[kbc_pkg::CFG_KIRQ]; // RL6 RL18
      airq_next = obf_next && ob_next.aux && cfg_next[kbc_pkg::CFG_AIRQ]; // RL18
      oe_next = {ts_next == kbc_pkg::TS_DRIVE && t_aux_next,
                 cfg_next[kbc_pkg::CFG_ADIS] || (ts_next == kbc_pkg::TS_DRIVE && t_aux_next),
                 ts_next == kbc_pkg::TS_DRIVE && !t_aux_next,
                 cfg_next[kbc_pkg::CFG_KDIS] || (ts_next == kbc_pkg::TS_DRIVE && !t_aux_next)};
      out_pin_next = outp_next & ~{4'h0, pmask_next}; // RL21
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ibf_reg <= 1'b0;
         cd_reg <= 1'b0;
         ib_reg <= 8'h00;
         obf_reg <= 1'b0;
         ob_reg <= '0;
         cfg_reg <= kbc_pkg::CFG_RST;
         outp_reg <= kbc_pkg::OUTP_RST;
         pend_reg <= kbc_pkg::PD_NONE;
         ts_reg <= kbc_pkg::TS_IDLE;
         poll_hi_reg <= 1'b0;
         poll_lo_reg <= 1'b0;
         lock_reg <= 1'b0;
         t_aux_reg <= 1'b0;
         cnt_reg <= 9'h000;
         pmask_reg <= 4'h0;
         pw_mem <= '{default: 8'h00};
         pw_len_reg <= 4'h0;
         pw_idx_reg <= 4'h0;
         host_rdata_reg <= 8'h00;
         rx_ready_reg <= 1'b0;
         keyboard_interrupt_line_reg <= 1'b0;
         pointer_interrupt_line_reg <= 1'b0;
         line_out_reg <= 4'h0;
         line_oe_reg <= 4'h0;
         out_port_reg <= kbc_pkg::OUTP_RST;
      end else if (clk_en) begin
         ibf_reg <= ibf_next;
         cd_reg <= cd_next;
         ib_reg <= ib_next;
         obf_reg <= obf_next;
         ob_reg <= ob_next;
         cfg_reg <= cfg_next;
         outp_reg <= outp_next;
         pend_reg <= pend_next;
         ts_reg <= ts_next;
         poll_hi_reg <= poll_hi_next;
         poll_lo_reg <= poll_lo_next;
         lock_reg <= lock_next;
         t_aux_reg <= t_aux_next;
         cnt_reg <= cnt_next;
         pmask_reg <= pmask_next;
         pw_mem <= pw_mem_next;
         pw_len_reg <= pw_len_next;
         pw_idx_reg <= pw_idx_next;
         host_rdata_reg <= rdata_next;
         rx_ready_reg <= rxr_next;
         keyboard_interrupt_line_reg <= kirq_next;
         pointer_interrupt_line_reg <= airq_next;
         line_out_reg <= 4'h0;
         line_oe_reg <= oe_next;
         out_port_reg <= out_pin_next;
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic cmd_go;
   assign cmd_go = clk_en && consume && cd_reg && !lock_reg;
   a_ibf_on_write: assert property (clk_en && host_wr |=> ibf_reg) // RL3
      else $error("input full not set by write");
   a_cd_tracks_a2: assert property (clk_en && host_wr |=> cd_reg == $past(host_address_bit_two)) // RL2
      else $error("command flag does not follow address bit");
   a_obf_read_clr: assert property (clk_en && host_rd && !host_address_bit_two && obf_reg
                                    |=> !obf_reg && host_rdata_reg == $past(ob_reg.data)) // RL4
      else $error("data read did not clear output full");
   a_status_read: assert property (clk_en && host_rd && host_address_bit_two && !poll_lo_reg
                                   |=> host_rdata_reg[1:0] == $past({ibf_reg, obf_reg})) // RL1
      else $error("status read wrong");
   a_cfg_read: assert property (cmd_go && ib_reg == kbc_pkg::CMD_RD_CFG
                                |=> obf_reg && ob_reg.data == $past(cfg_reg)) // RL7
      else $error("configuration read wrong");
   a_pw_test_rsp: assert property (cmd_go && ib_reg == kbc_pkg::CMD_PW_TEST |=> ob_reg.data ==
      ($past(pw_len_reg) != 4'h0 ? kbc_pkg::RSP_PW_YES : kbc_pkg::RSP_PW_NO)) // RL8
      else $error("password test answer wrong");
   a_init_rsp: assert property (cmd_go && ib_reg == kbc_pkg::CMD_INIT
                                |=> ob_reg.data == kbc_pkg::RSP_INIT && cfg_reg[5:4] == 2'h3) // RL13
      else $error("init answer wrong");
   a_aux_clk_hold: assert property (cfg_reg[kbc_pkg::CFG_ADIS] |-> line_oe_reg[2]) // RL11
      else $error("pointer clock not held low");
   a_reset_pulse: assert property (cmd_go && ib_reg == 8'hfe |=> ##1 !out_port_reg[0] [*8]) // RL21
      else $error("reset pulse too short");
   a_kirq_cause: assert property (keyboard_interrupt_line_reg |-> obf_reg && !ob_reg.aux) // RL6
      else $error("keyboard interrupt without data");
   a_outp_bit1: assert property (clk_en && consume && !cd_reg && !lock_reg && pend_reg ==
      kbc_pkg::PD_OUTP |=> outp_reg[7:2] == $past(outp_reg[7:2])) // RL17
      else $error("output port changed beyond bit 1");
   c_echo: cover property (cmd_go && ib_reg == kbc_pkg::CMD_ECHO_KBD ##[1:40] kirq_next);
   c_lock: cover property (lock_reg ##[1:200] !lock_reg);
   c_test_done: cover property (ts_reg == kbc_pkg::TS_DRIVE ##[1:500] ts_reg == kbc_pkg::TS_IDLE);
   c_tx_stall: cover property (skid_v_reg && tx_valid_reg && !tx_ready);
endmodule : kbc_host_port
`default_nettype wire

// ===== rtl/kbc_pkg.sv
// Package: constants and types of the keyboard controller host port
package kbc_pkg;
   // ************************************************
   // Host ports, status and configuration fields
   // ************************************************
   localparam logic [7:0] PORT_DATA = 8'h60;
   localparam logic [7:0] PORT_CMD = 8'h64;
   localparam int ST_OBF = 0;
   localparam int ST_IBF = 1;
   localparam int ST_SYS = 2;
   localparam int ST_CD = 3;
   localparam int CFG_KIRQ = 0;
   localparam int CFG_AIRQ = 1;
   localparam int CFG_SYS = 2;
   localparam int CFG_KDIS = 4;
   localparam int CFG_ADIS = 5;
   localparam int OUTP_SYSRST = 0;
   localparam int OUTP_GATE = 1;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] OUTP_RST = 8'hff;
   localparam logic [3:0] STAT_GP_RST = 4'h0;
   localparam int PW_MAX = 8;
   // ************************************************
   // Commands and answers
   // ************************************************
   localparam logic [7:0] CMD_RD_CFG = 8'h20;
   localparam logic [7:0] CMD_WR_CFG = 8'h60;
   localparam logic [7:0] CMD_PW_TEST = 8'ha4;
   localparam logic [7:0] CMD_PW_LOAD = 8'ha5;
   localparam logic [7:0] CMD_PW_LOCK = 8'ha6;
   localparam logic [7:0] CMD_AUX_DIS = 8'ha7;
   localparam logic [7:0] CMD_AUX_EN = 8'ha8;
   localparam logic [7:0] CMD_AUX_TEST = 8'ha9;
   localparam logic [7:0] CMD_INIT = 8'haa;
   localparam logic [7:0] CMD_KBD_TEST = 8'hab;
   localparam logic [7:0] CMD_KBD_DIS = 8'had;
   localparam logic [7:0] CMD_KBD_EN = 8'hae;
   localparam logic [7:0] CMD_RD_INP = 8'hc0;
   localparam logic [7:0] CMD_POLL_HI = 8'hc2;
   localparam logic [7:0] CMD_POLL_LO = 8'hc3;
   localparam logic [7:0] CMD_RD_OUTP = 8'hd0;
   localparam logic [7:0] CMD_WR_OUTP = 8'hd1;
   localparam logic [7:0] CMD_ECHO_KBD = 8'hd2;
   localparam logic [7:0] CMD_ECHO_AUX = 8'hd3;
   localparam logic [7:0] CMD_WR_AUX = 8'hd4;
   localparam logic [7:0] CMD_RD_TEST = 8'he0;
   localparam logic [3:0] CMD_PULSE_HI = 4'hf;
   localparam logic [7:0] PW_END = 8'h00;
   localparam logic [7:0] RSP_PW_YES = 8'hfa;
   localparam logic [7:0] RSP_PW_NO = 8'hf1;
   localparam logic [7:0] RSP_INIT = 8'h55;
   localparam logic [7:0] LT_OK = 8'h00;
   localparam logic [7:0] LT_CLK_LO = 8'h01;
   localparam logic [7:0] LT_CLK_HI = 8'h02;
   localparam logic [7:0] LT_DAT_LO = 8'h03;
   localparam logic [7:0] LT_DAT_HI = 8'h04;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_MHZ = 40;
   localparam int SETTLE_NS = 10000;
   localparam int PULSE_NS = 6000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   // ************************************************
   // Types
   // ************************************************
   typedef struct packed {
      logic aux;
      logic [7:0] data;
   } kbc_byte_t;
   typedef enum logic [2:0] {
      PD_NONE = 3'h0, PD_CFG = 3'h1, PD_PW = 3'h3, PD_OUTP = 3'h2,
      PD_ECHO_K = 3'h6, PD_ECHO_A = 3'h7, PD_AUX = 3'h5
   } kbc_pend_t;
   typedef enum logic [1:0] {
      TS_IDLE = 2'h0, TS_REL = 2'h1, TS_DRIVE = 2'h3
   } kbc_test_t;
endpackage : kbc_pkg

// ===== testbench/kbc_serial_model.sv
// Serial-side model: keyboard and pointer byte source and sink
`timescale 1ns/10ps
`default_nettype none
module kbc_serial_model (
   input wire logic clk_sys,
   input wire logic send,
   input wire kbc_pkg::kbc_byte_t send_word,
   input wire logic tx_valid_reg,
   input wire kbc_pkg::kbc_byte_t tx_word_reg,
   output logic tx_ready,
   output kbc_pkg::kbc_byte_t last_tx,
   output logic rx_valid,
   output kbc_pkg::kbc_byte_t rx_word,
   input wire logic rx_ready_reg,
   input wire logic [3:0] line_oe_reg,
   output logic [3:0] line_in
);
   // Lines have pull-ups, so they read high unless pulled low
   assign line_in = ~line_oe_reg;
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_word = '0;
      last_tx = '0;
   end
   // Sink takes a byte only every other cycle, so the buffer sees stalls
   always @(posedge clk_sys) begin
      tx_ready <= ~tx_ready;
      if (tx_valid_reg && tx_ready) begin
         last_tx <= tx_word_reg;
      end
      if (rx_valid && rx_ready_reg) begin
         rx_valid <= 1'b0;
         rx_word <= ~rx_word;
      end else if (send) begin
         rx_valid <= 1'b1;
         rx_word <= send_word;
      end
   end
endmodule : kbc_serial_model
`default_nettype wire

// ===== testbench/keyboard_controller_host_port_tb.sv
// Testbench: host port command sequences with expected answers
`timescale 1ns/10ps
`default_nettype none
module keyboard_controller_host_port_tb;
   logic clk_sys = 1'b0, rst_b = 1'b0, host_rd = 1'b0, host_wr = 1'b0, a2 = 1'b0, send = 1'b0;
   logic [7:0] wdata = 8'h00, v, rdata, outp;
   logic kirq, pirq, rx_valid, rx_ready, tx_valid, tx_ready;
   logic [3:0] line_in, line_oe;
   kbc_pkg::kbc_byte_t send_word = '0, last_tx, rx_word, tx_word;
   int failures = 0, comparisons = 0, cycles = 0;
   always #12.5 clk_sys = ~clk_sys;
   kbc_host_port dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .host_rd(host_rd),
      .host_wr(host_wr), .host_address_bit_two(a2), .host_wdata(wdata), .host_rdata_reg(rdata),
      .keyboard_interrupt_line_reg(kirq), .pointer_interrupt_line_reg(pirq), .rx_valid(rx_valid),
      .rx_word(rx_word), .rx_ready_reg(rx_ready), .tx_valid_reg(tx_valid), .tx_word_reg(tx_word),
      .tx_ready(tx_ready), .in_port_pin(8'h5a), .test_pin(2'h2), .line_in(line_in),
      .line_out_reg(), .line_oe_reg(line_oe), .out_port_reg(outp));
   kbc_serial_model far_u (.clk_sys(clk_sys), .send(send), .send_word(send_word),
      .tx_valid_reg(tx_valid), .tx_word_reg(tx_word), .tx_ready(tx_ready), .last_tx(last_tx),
      .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready_reg(rx_ready), .line_oe_reg(line_oe),
      .line_in(line_in));
   task automatic give_verdict;
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic chk(string name, logic [8:0] seen, logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Serial side offers one byte, then the bench waits for it to land
   task automatic snd(logic [8:0] w);
      @(negedge clk_sys) send_word = w;
      send = 1'b1;
      @(negedge clk_sys) send = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask : snd
   task automatic rd(logic adr, output logic [7:0] d);
      @(negedge clk_sys) host_rd = 1'b1;
      a2 = adr;
      @(negedge clk_sys) host_rd = 1'b0;
      d = rdata;
   endtask : rd
   // Poll input-full first: a write over a full buffer would overwrite the pending byte
   task automatic wr(logic adr, logic [7:0] d);
      logic [7:0] s;
      do rd(1'b1, s); while (s[1] !== 1'b0);
      @(negedge clk_sys) host_wr = 1'b1;
      a2 = adr;
      wdata = d;
      @(negedge clk_sys) host_wr = 1'b0;
   endtask : wr
   task automatic ask(logic [7:0] c, logic [7:0] e);
      int n;
      wr(1'b1, c);
      n = 0;
      do begin
         rd(1'b1, v);
         n++;
      end while (v[0] !== 1'b1 && n < 1000);
      rd(1'b0, v);
      chk("answer", {1'b0, v}, {1'b0, e});
   endtask : ask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict;
      end
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      rd(1'b1, v);
      chk("status", {1'b0, v}, 9'h000);
      ask(8'h20, 8'h00);
      ask(8'ha4, 8'hf1);
      ask(8'hc0, 8'h5a);
      ask(8'hd0, 8'hff);
      ask(8'he0, 8'h02);
      ask(8'hab, 8'h00);
      ask(8'ha9, 8'h00);
      ask(8'haa, 8'h55);
      wr(1'b1, 8'h60);
      wr(1'b0, 8'h01);
      ask(8'h20, 8'h01);
      wr(1'b1, 8'ha8);
      repeat (3) @(negedge clk_sys);
      rd(1'b1, v);
      chk("status", {1'b0, v}, 9'h008);
      wr(1'b1, 8'hd4);
      wr(1'b0, 8'h77);
      repeat (8) @(negedge clk_sys);
      chk("tx", last_tx, 9'h177);
      rd(1'b1, v);
      chk("status", {1'b0, v}, 9'h000);
      snd(9'h03c);
      chk("kirq", {8'h00, kirq}, 9'h001);
      rd(1'b0, v);
      chk("data", {1'b0, v}, 9'h03c);
      rd(1'b1, v);
      chk("status", {1'b0, v}, 9'h000);
      wr(1'b1, 8'had);
      ask(8'h20, 8'h11);
      wr(1'b1, 8'ha7);
      ask(8'h20, 8'h31);
      wr(1'b1, 8'hd1);
      wr(1'b0, 8'h00);
      ask(8'hd0, 8'hfd);
      wr(1'b1, 8'ha5);
      wr(1'b0, 8'h1c);
      wr(1'b0, 8'h00);
      ask(8'ha4, 8'hfa);
      wr(1'b1, 8'ha6);
      wr(1'b1, 8'h20);
      repeat (4) @(negedge clk_sys);
      rd(1'b1, v);
      chk("locked", {1'b0, v}, 9'h008);
      snd(9'h01c);
      ask(8'h20, 8'h31);
      wr(1'b1, 8'h60);
      wr(1'b0, 8'h02);
      wr(1'b1, 8'hd3);
      wr(1'b0, 8'h5e);
      repeat (2) @(negedge clk_sys);
      chk("pirq", {8'h00, pirq}, 9'h001);
      rd(1'b0, v);
      chk("echo", {1'b0, v}, 9'h05e);
      wr(1'b1, 8'hfe);
      repeat (4) @(negedge clk_sys);
      chk("pulse", {1'b0, outp}, 9'h0fc);
      repeat (250) @(negedge clk_sys);
      chk("pulse", {1'b0, outp}, 9'h0fd);
      wr(1'b1, 8'hc2);
      repeat (2) @(negedge clk_sys);
      rd(1'b1, v);
      chk("poll", {1'b0, v}, 9'h058);
      // Low-nibble polling hides the input-full bit, so it stays last
      wr(1'b1, 8'hc3);
      repeat (2) @(negedge clk_sys);
      rd(1'b1, v);
      chk("poll", {1'b0, v}, 9'h00a);
      give_verdict;
   end
endmodule : keyboard_controller_host_port_tb
`default_nettype wire
